/* File: core/srctl_pkg.sv */
// Shared types and constants of the system reset controller
package srctl_pkg;

  // Reset sources, packed in cause-flag order: bit 3 down to bit 0
  typedef struct packed {
    logic wdt;
    logic droop;
    logic pin;
    logic por;
  } srctl_src_t;

  localparam int FLAG_WDT   = 3;
  localparam int FLAG_DROOP = 2;
  localparam int FLAG_PIN   = 1;
  localparam int FLAG_POR   = 0;

  // Fuse encoding of the supply droop detector mode
  typedef enum logic [1:0] {
    DM_RSVD    = 2'h0,
    DM_SAMPLED = 2'h1,
    DM_CONT    = 2'h2,
    DM_OFF     = 2'h3
  } srctl_dmode_t;

  // Internal reset sequence, Gray coded along run, hold, stretch
  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_HOLD    = 2'h1,
    ST_STRETCH = 2'h3
  } srctl_state_t;

  // Live status word, read at ADDR_LIVE
  typedef struct packed {
    logic [1:0]   zero;
    srctl_dmode_t mode;
    logic         forced_cont;
    logic         ref_en;
    logic         det_en;
    logic         core_reset;
  } srctl_live_t;

  localparam logic [1:0] ADDR_CAUSE = 2'h0;
  localparam logic [1:0] ADDR_ISTAT = 2'h1;
  localparam logic [1:0] ADDR_IMASK = 2'h2;
  localparam logic [1:0] ADDR_LIVE  = 2'h3;

  localparam logic [3:0] CAUSE_RST    = 4'h0;
  localparam logic [3:0] CAUSE_POR    = 4'h1;
  localparam logic [3:0] ISTAT_RST    = 4'h0;
  localparam logic [3:0] IMASK_RST    = 4'h0;
  localparam logic [3:0] SYNC_RST     = 4'h0;

  localparam int STRETCH_CYC_DEF = 64;
  localparam int PIN_MIN_CYC_DEF = 8;
  localparam int DROOP_CYC_DEF   = 16;

endpackage : srctl_pkg

/* File: core/srctl_top.sv */
// System reset controller: reset sources, stretch, droop modes, reference
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module srctl_top #(
  parameter int STRETCH_CYC = srctl_pkg::STRETCH_CYC_DEF,
  parameter int PIN_MIN_CYC = srctl_pkg::PIN_MIN_CYC_DEF,
  parameter int DROOP_CYC   = srctl_pkg::DROOP_CYC_DEF
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       por_low_i,
  input  wire logic       pin_n_i,
  input  wire logic       pin_func_en_i,
  input  wire logic       wdt_timeout_i,
  input  wire logic       wdt_en_i,
  input  wire logic       droop_low_i,
  input  wire logic       ulp_tick_i,
  input  wire logic [1:0] droop_mode_active_fuse_i,
  input  wire logic [1:0] droop_mode_sleep_fuse_i,
  input  wire logic       deep_sleep_i,
  input  wire logic       fuse_loaded_i,
  input  wire logic       comparator_ref_select_i,
  input  wire logic       adc_en_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  output logic            io_reset_o,
  output logic            core_reset_o,
  output logic            fetch_start_o,
  output logic            supply_droop_detector_en_o,
  output logic            ref_en_o,
  output logic            irq_o
);
  import srctl_pkg::*;

  localparam int SW = $clog2(STRETCH_CYC);
  localparam int PW = $clog2(PIN_MIN_CYC);
  localparam int DW = $clog2(DROOP_CYC);
  localparam logic [SW-1:0] CNT_LAST   = SW'(STRETCH_CYC - 1);
  localparam logic [PW-1:0] PIN_LAST   = PW'(PIN_MIN_CYC - 1);
  localparam logic [DW-1:0] DROOP_LAST = DW'(DROOP_CYC - 1);

  if (STRETCH_CYC < 2 || PIN_MIN_CYC < 2 || DROOP_CYC < 2) begin : g_chk
    $error("srctl_top: filter and stretch lengths must be at least 2");
  end

  logic [3:0]      sync1;
  logic [3:0]      sync2;
  logic [3:0]      sync3;
  logic [3:0]      lvl;
  logic            tick_q;
  srctl_state_t    st;
  logic [SW-1:0]   cnt;
  logic            por_phase;
  logic [PW-1:0]   pin_cnt;
  logic            pin_req;
  logic [DW-1:0]   droop_cnt;
  logic            droop_req;
  logic            forced_cont;
  logic            wdt_pulse;
  logic            core_q;
  srctl_src_t      src;
  srctl_src_t      src_q;
  srctl_src_t      ev;
  logic            any_src;
  logic            pin_lo;
  logic            droop_lo;
  logic            tick_fall;
  logic            samp_now;
  logic            droop_on;
  srctl_dmode_t    fuse_mode;
  srctl_dmode_t    eff_mode;
  logic [3:0]      cause;
  logic [3:0]      istat;
  logic [3:0]      imask;
  logic [3:0]      next_cause;
  logic [3:0]      next_istat;
  srctl_live_t     live;

  // Async pin-facing path: no clock is needed to park the ports
  assign io_reset_o = por_low_i | (pin_func_en_i & ~pin_n_i) |
                      (wdt_timeout_i & wdt_en_i) |
                      (droop_low_i & droop_on) | core_reset_o;

  // Three-stage sync; level changes once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
      lvl   <= SYNC_RST;
    end else begin
      sync1 <= {ulp_tick_i, droop_low_i, ~pin_n_i, por_low_i};
      sync2 <= sync1;
      sync3 <= sync2;
      lvl   <= (sync2 & sync3) | (lvl & (sync2 | sync3));
    end
  end

  assign pin_lo    = lvl[1] & pin_func_en_i;
  assign droop_lo  = lvl[2];
  assign tick_fall = tick_q & ~lvl[3];

  // Mode from fuses; reserved code treated as continuous, the safe side
  assign fuse_mode = srctl_dmode_t'(deep_sleep_i ? droop_mode_sleep_fuse_i
                                    : droop_mode_active_fuse_i);
  always_comb begin
    if (forced_cont || fuse_mode == DM_RSVD) begin
      eff_mode = DM_CONT;
    end else begin
      eff_mode = fuse_mode;
    end
  end
  assign droop_on = (eff_mode != DM_OFF);
  assign samp_now = (eff_mode == DM_SAMPLED) && tick_fall;

  assign src.por   = lvl[0];
  assign src.pin   = pin_req & ~por_phase;
  assign src.wdt   = wdt_pulse;
  assign src.droop = droop_req;
  assign any_src   = |src;
  assign ev        = src & ~src_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_q    <= 1'b0;
      wdt_pulse <= 1'b0;
      src_q     <= '0;
      core_q    <= 1'b1;
    end else begin
      tick_q    <= lvl[3];
      wdt_pulse <= wdt_timeout_i & wdt_en_i;
      src_q     <= src;
      core_q    <= core_reset_o;
    end
  end

  // Pin filter: shorter pulses never reach the source
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_cnt <= '0;
      pin_req <= 1'b0;
    end else if (!pin_lo) begin
      pin_cnt <= '0;
      pin_req <= 1'b0;
    end else if (pin_cnt == PIN_LAST) begin
      pin_req <= 1'b1;
    end else begin
      pin_cnt <= pin_cnt + 1'b1;
    end
  end

  // Droop detection: continuous filter, or one look per falling tick edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      droop_cnt <= '0;
      droop_req <= 1'b0;
    end else begin
      if (eff_mode == DM_CONT && droop_lo) begin
        if (droop_cnt != DROOP_LAST) begin
          droop_cnt <= droop_cnt + 1'b1;
        end
      end else begin
        droop_cnt <= '0;
      end
      if (!droop_lo || eff_mode == DM_OFF) begin
        droop_req <= 1'b0;
      end
      if (eff_mode == DM_CONT && droop_lo && droop_cnt == DROOP_LAST) begin
        droop_req <= 1'b1;
      end
      if (samp_now && droop_lo) begin
        droop_req <= 1'b1;
      end
    end
  end

  // Forced continuous mode; held until reset ends, the request drops and fuses load
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      forced_cont <= 1'b0;
    end else if (samp_now && droop_lo) begin
      forced_cont <= 1'b1;
    end else if (!core_reset_o && !droop_req && fuse_loaded_i) begin
      forced_cont <= 1'b0;
    end
  end

  // Detector power: settling before the sample edge is the analog side's
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      supply_droop_detector_en_o <= 1'b0;
      ref_en_o                   <= 1'b0;
    end else begin
      supply_droop_detector_en_o <= (eff_mode == DM_CONT) ||
                                    samp_now;
      ref_en_o <= droop_on | comparator_ref_select_i | adc_en_i;
    end
  end

  // Internal reset sequence and stretch counter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st  <= ST_HOLD;
      cnt <= '0;
    end else begin
      case (st)
        ST_RUN: begin
          if (any_src) begin
            st <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt <= '0;
          if (!any_src) begin
            st <= ST_STRETCH;
          end
        end
        ST_STRETCH: begin
          if (any_src) begin
            st <= ST_HOLD;
          end else if (cnt == CNT_LAST) begin
            cnt <= '0;
            if (!(por_phase && pin_lo)) begin
              st <= ST_RUN;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          st <= ST_HOLD;
        end
      endcase
    end
  end

  // Power-on start-up count window, pin is masked within it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      por_phase <= 1'b1;
    end else if (src.por) begin
      por_phase <= 1'b1;
    end else if (st == ST_STRETCH && cnt == CNT_LAST) begin
      por_phase <= 1'b0;
    end
  end

  assign core_reset_o = (st != ST_RUN);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fetch_start_o <= 1'b0;
    end else begin
      fetch_start_o <= core_q & ~core_reset_o;
    end
  end

  // Cause flags: zero write clears, new events win, power-on wipes others
  always_comb begin
    next_cause = cause;
    if (wr_i && addr_i == ADDR_CAUSE) begin
      next_cause = next_cause & wr_data_i[3:0];
    end
    next_cause = next_cause | ev;
    if (ev.por) begin
      next_cause = CAUSE_POR;
    end
  end

  always_comb begin
    next_istat = istat;
    if (wr_i && addr_i == ADDR_ISTAT) begin
      next_istat = next_istat & ~wr_data_i[3:0];
    end
    next_istat = next_istat | ev;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cause <= CAUSE_RST;
      istat <= ISTAT_RST;
      imask <= IMASK_RST;
    end else begin
      cause <= next_cause;
      istat <= next_istat;
      if (wr_i && addr_i == ADDR_IMASK) begin
        imask <= wr_data_i[3:0];
      end
    end
  end

  assign irq_o = |(istat & imask);

  assign live = '{zero: 2'h0, mode: eff_mode, forced_cont: forced_cont,
                  ref_en: ref_en_o, det_en: supply_droop_detector_en_o,
                  core_reset: core_reset_o};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !rd_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (addr_i)
        ADDR_CAUSE: rd_data_o <= {4'h0, cause};
        ADDR_ISTAT: rd_data_o <= {4'h0, istat};
        ADDR_IMASK: rd_data_o <= {4'h0, imask};
        ADDR_LIVE:  rd_data_o <= live;
        default:    rd_data_o <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_SRC_RESET: assert property (
    any_src |=> core_reset_o) else $error("source did not hold reset");
  AST_STRETCH_LEN: assert property (
    $fell(core_reset_o) |-> $past(cnt) == CNT_LAST && !$past(any_src))
    else $error("reset released before full stretch");
  AST_POR_ASYNC: assert property (
    por_low_i |-> io_reset_o) else $error("io reset missing on power low");
  AST_POR_NO_DELAY: assert property (
    src.por |=> st == ST_HOLD) else $error("power-on reset delayed");
  AST_PIN_RELEASE: assert property (
    !pin_lo |=> !pin_req) else $error("pin request outlived pin low");
  AST_POR_MASK: assert property (
    por_phase |-> !src.pin) else $error("pin seen in power-on count");
  AST_POR_EXTEND: assert property (
    (st == ST_STRETCH && cnt == CNT_LAST && por_phase && pin_lo && !any_src)
    |=> core_reset_o) else $error("low pin did not extend reset");
  AST_WDT: assert property (
    (wdt_timeout_i && wdt_en_i) |=> wdt_pulse ##1 core_reset_o)
    else $error("watchdog timeout gave no reset");
  AST_DROOP_HOLD: assert property (
    (droop_req && droop_lo && eff_mode != DM_OFF) |=> droop_req)
    else $error("droop reset dropped while supply low");
  AST_OFF: assert property (
    (eff_mode == DM_OFF) |=> !supply_droop_detector_en_o)
    else $error("detector powered in disabled mode");
  AST_SAMPLE_SWITCH: assert property (
    (samp_now && droop_lo) |=> forced_cont && droop_req)
    else $error("sampled detection did not force continuous");
  AST_REF_OFF: assert property (
    !(droop_on || comparator_ref_select_i || adc_en_i) |=> !ref_en_o)
    else $error("reference on without requester");
  AST_POR_CLEARS: assert property (
    ev.por |=> cause == CAUSE_POR) else $error("power-on flags wrong");

  COV_WDT_CYCLE: cover property (
    $rose(wdt_pulse) ##[1:300] $fell(core_reset_o));
  COV_SAMPLED: cover property (samp_now && droop_lo);
  COV_POR_EXT: cover property (
    st == ST_STRETCH && cnt == CNT_LAST && por_phase && pin_lo);
  COV_IRQ: cover property ($rose(irq_o));

endmodule : srctl_top

/* File: sim/tb_srctl_top.sv */
// Self-checking testbench of the system reset controller
`timescale 1ns/1ps
module tb_srctl_top;
  import srctl_pkg::*;

  // Short counts keep the run brief; expectations derive from these
  localparam int STR = 4;

  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       por_low_i = 1'b1;
  logic       pin_n_i = 1'b0;
  logic       pin_func_en_i = 1'b1;
  logic       wdt_timeout_i = 1'b0;
  logic       wdt_en_i = 1'b0;
  logic       droop_low_i = 1'b0;
  logic       ulp_tick_i = 1'b0;
  logic [1:0] act_fuse = 2'h3;
  logic [1:0] slp_fuse = 2'h3;
  logic       deep_sleep_i = 1'b0;
  logic       fuse_loaded_i = 1'b1;
  logic       cmp_sel = 1'b0;
  logic       adc_en_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rd_data_o;
  logic       io_reset_o;
  logic       core_reset_o;
  logic       fetch_start_o;
  logic       det_en;
  logic       ref_en_o;
  logic       irq_o;
  int         n_errors = 0;
  int         total_checks = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  srctl_top #(.STRETCH_CYC(STR), .PIN_MIN_CYC(2), .DROOP_CYC(2)) i_srctl_top (
    .ref_clk_i                  (ref_clk_i),
    .rst_i                      (rst_i),
    .por_low_i                  (por_low_i),
    .pin_n_i                    (pin_n_i),
    .pin_func_en_i              (pin_func_en_i),
    .wdt_timeout_i              (wdt_timeout_i),
    .wdt_en_i                   (wdt_en_i),
    .droop_low_i                (droop_low_i),
    .ulp_tick_i                 (ulp_tick_i),
    .droop_mode_active_fuse_i   (act_fuse),
    .droop_mode_sleep_fuse_i    (slp_fuse),
    .deep_sleep_i               (deep_sleep_i),
    .fuse_loaded_i              (fuse_loaded_i),
    .comparator_ref_select_i    (cmp_sel),
    .adc_en_i                   (adc_en_i),
    .addr_i                     (addr_i),
    .wr_data_i                  (wr_data_i),
    .wr_i                       (wr_i),
    .rd_i                       (rd_i),
    .rd_data_o                  (rd_data_o),
    .io_reset_o                 (io_reset_o),
    .core_reset_o               (core_reset_o),
    .fetch_start_o              (fetch_start_o),
    .supply_droop_detector_en_o (det_en),
    .ref_en_o                   (ref_en_o),
    .irq_o                      (irq_o)
  );

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : step

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge ref_clk_i);
    wr_i      <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [1:0] a, input logic [7:0] msk, exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 chk("reg", rd_data_o & msk, exp);
    @(posedge ref_clk_i);
    #1 chk("reg idle", rd_data_o, 8'h00);
  endtask : rchk

  task automatic wait_rst(input logic lvl);
    int k;
    k = 0;
    while (core_reset_o !== lvl && k < 300) begin
      @(posedge ref_clk_i);
      #1 k++;
    end
    if (k >= 300) begin
      n_errors++;
      $display("BAD core_reset wait exp %b", lvl);
      results();
    end
  endtask : wait_rst

  // Counts further cycles of reset, then checks the fetch pulse after it
  task automatic hi_len(output int n);
    n = 0;
    while (core_reset_o === 1'b1 && n < 300) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    @(posedge ref_clk_i);
    #1 chk("fetch", fetch_start_o, 1'b1);
    @(posedge ref_clk_i);
    #1 chk("fetch", fetch_start_o, 1'b0);
  endtask : hi_len

  task automatic first_power_on();
    step(5);
    rst_i <= 1'b0;
    step(3);
    por_low_i <= 1'b0;
    step(30);
    #1 chk("pin ext", core_reset_o, 1'b1);
    @(posedge ref_clk_i);
    pin_n_i <= 1'b1;
    wait_rst(1'b0);
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_ISTAT, 8'h0f);
  endtask : first_power_on

  task automatic wdt_reset();
    int n;
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'b0;
    step(8);
    #1 chk("wdt off", core_reset_o, 1'b0);
    @(posedge ref_clk_i);
    wdt_en_i      <= 1'b1;
    wdt_timeout_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'b0;
    wait_rst(1'b1);
    hi_len(n);
    chk("wdt len", 8'(n), 8'(STR + 1));
    rchk(ADDR_CAUSE, 8'hff, 8'h08);
    #1 chk("irq masked", irq_o, 1'b0);
    wr(ADDR_IMASK, 8'h08);
    #1 chk("irq", irq_o, 1'b1);
    wr(ADDR_ISTAT, 8'h08);
    #1 chk("irq clr", irq_o, 1'b0);
  endtask : wdt_reset

  task automatic power_on_again();
    int n;
    @(posedge ref_clk_i);
    por_low_i <= 1'b1;
    #1 chk("io por", io_reset_o, 1'b1);
    step(8);
    por_low_i <= 1'b0;
    // Back low inside the stretch: reset must return without a release
    step(2);
    por_low_i <= 1'b1;
    step(8);
    #1 chk("por again", core_reset_o, 1'b1);
    @(posedge ref_clk_i);
    por_low_i <= 1'b0;
    hi_len(n);
    chk("por len", 8'(n > STR), 8'h01);
    rchk(ADDR_CAUSE, 8'hff, 8'h01);
    wr(ADDR_CAUSE, 8'h00);
    rchk(ADDR_CAUSE, 8'hff, 8'h00);
  endtask : power_on_again

  task automatic pin_reset();
    int n;
    @(posedge ref_clk_i);
    pin_func_en_i <= 1'b0;
    pin_n_i       <= 1'b0;
    step(10);
    pin_n_i       <= 1'b1;
    // Let the synced low drain before enabling, else it counts as a reset
    step(6);
    pin_func_en_i <= 1'b1;
    #1 chk("pin off", core_reset_o, 1'b0);
    @(posedge ref_clk_i);
    pin_n_i <= 1'b0;
    #1 chk("io pin", io_reset_o, 1'b1);
    @(posedge ref_clk_i);
    pin_n_i <= 1'b1;
    step(8);
    #1 chk("pin short", core_reset_o, 1'b0);
    @(posedge ref_clk_i);
    pin_n_i <= 1'b0;
    step(10);
    pin_n_i <= 1'b1;
    #1 chk("pin long", core_reset_o, 1'b1);
    hi_len(n);
    chk("pin len", 8'(n > STR), 8'h01);
    rchk(ADDR_CAUSE, 8'hff, 8'h02);
    wr(ADDR_CAUSE, 8'h00);
  endtask : pin_reset

  task automatic droop_modes();
    int n;
    @(posedge ref_clk_i);
    droop_low_i <= 1'b1;
    step(10);
    #1 chk("off", {core_reset_o, det_en, ref_en_o}, 3'h0);
    @(posedge ref_clk_i);
    droop_low_i <= 1'b0;
    act_fuse    <= 2'h2;
    step(6);
    #1 chk("cont", {det_en, ref_en_o}, 2'h3);
    @(posedge ref_clk_i);
    droop_low_i <= 1'b1;
    @(posedge ref_clk_i);
    droop_low_i <= 1'b0;
    step(8);
    #1 chk("glitch", core_reset_o, 1'b0);
    @(posedge ref_clk_i);
    droop_low_i <= 1'b1;
    wait_rst(1'b1);
    step(20);
    #1 chk("droop hold", core_reset_o, 1'b1);
    @(posedge ref_clk_i);
    droop_low_i <= 1'b0;
    wait_rst(1'b0);
    rchk(ADDR_CAUSE, 8'hff, 8'h04);
    // Sampled mode: one detector pulse per falling tick
    @(posedge ref_clk_i);
    act_fuse <= 2'h1;
    step(10);
    #1 chk("idle det", det_en, 1'b0);
    @(posedge ref_clk_i);
    ulp_tick_i <= 1'b1;
    step(8);
    ulp_tick_i <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge ref_clk_i);
      #1 n += int'(det_en === 1'b1);
    end
    chk("sample", 8'(n), 8'h01);
    @(posedge ref_clk_i);
    droop_low_i <= 1'b1;
    ulp_tick_i  <= 1'b1;
    step(8);
    ulp_tick_i  <= 1'b0;
    wait_rst(1'b1);
    step(3);
    #1 chk("forced det", det_en, 1'b1);
    rchk(ADDR_LIVE, 8'h08, 8'h08);
    @(posedge ref_clk_i);
    droop_low_i <= 1'b0;
    wait_rst(1'b0);
    step(3);
    rchk(ADDR_LIVE, 8'h08, 8'h00);
    @(posedge ref_clk_i);
    slp_fuse     <= 2'h2;
    deep_sleep_i <= 1'b1;
    rchk(ADDR_LIVE, 8'h30, 8'h20);
    @(posedge ref_clk_i);
    deep_sleep_i <= 1'b0;
    rchk(ADDR_LIVE, 8'h30, 8'h10);
  endtask : droop_modes

  // Reference follows its comparator and ADC requesters
  task automatic ref_enable();
    @(posedge ref_clk_i);
    act_fuse <= 2'h3;
    step(4);
    #1 chk("ref off", ref_en_o, 1'b0);
    @(posedge ref_clk_i);
    cmp_sel <= 1'b1;
    // Software side waits for reference start-up before use
    step(3);
    #1 chk("ref cmp", ref_en_o, 1'b1);
    @(posedge ref_clk_i);
    cmp_sel  <= 1'b0;
    adc_en_i <= 1'b1;
    step(3);
    #1 chk("ref adc", ref_en_o, 1'b1);
    @(posedge ref_clk_i);
    adc_en_i <= 1'b0;
    step(3);
    #1 chk("ref none", ref_en_o, 1'b0);
  endtask : ref_enable

  initial begin
    first_power_on();
    wdt_reset();
    power_on_again();
    pin_reset();
    droop_modes();
    ref_enable();
    results();
  end
endmodule : tb_srctl_top
